/* verif/denoise_asserts.sv */
// port checker for the bayer texture filter
// assumes bound to the filter top, one clock
`timescale 1ns/100ps
module denoise_asserts
  import denoise_pkg::*;
#(
  parameter int PIX_W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [PIX_W-1:0] nb_centre,
  input wire logic [PIX_W-1:0] nb_top,
  input wire logic [PIX_W-1:0] nb_bottom,
  input wire logic [PIX_W-1:0] nb_left,
  input wire logic [PIX_W-1:0] nb_right,
  input wire logic in_eol,
  input wire logic in_eof,
  input wire denoise_pkg::filter_mode_e filter_mode,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [PIX_W-1:0] out_pixel,
  input wire logic out_eol,
  input wire logic out_eof,
  input wire denoise_pkg::texture_e out_class_dbg
);
  wire logic take = in_valid && in_ready;
  // uniform patch: every kernel must give back the centre
  wire logic uni = nb_top == nb_centre && nb_bottom == nb_centre
    && nb_left == nb_centre && nb_right == nb_centre;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // idle cycle first so stage one holds nothing older
  sequence s_take;
    !take ##1 (take && !out_valid);
  endsequence
  sequence s_take_uni;
    !take ##1 (take && !out_valid && uni);
  endsequence
  a_take_latency: assert property (s_take |-> ##2 out_valid)
    else $error("pixel late");
  a_mark_align: assert property (s_take |-> ##2 out_eol == $past(in_eol, 2)
    && out_eof == $past(in_eof, 2)) else $error("markers misaligned");
  a_bypass_centre: assert property (s_take ##1 filter_mode == MODE_BYPASS
    |-> ##1 out_pixel == $past(nb_centre, 2)) else $error("bypass altered pixel");
  a_flat_keep: assert property (s_take_uni |-> ##2 out_class_dbg == TEX_FLAT
    && out_pixel == $past(nb_centre, 2)) else $error("uniform patch changed");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid
    && $stable(out_pixel) && $stable(out_eol) && $stable(out_eof)) else $error("word not held");
  a_ready_full: assert property (!in_ready |-> out_valid)
    else $error("refused while empty");
  a_rise_cause: assert property ($rose(out_valid) |-> $past(take, 2))
    else $error("word without take");
  a_pop_ready: assert property (out_valid && out_ready |=> in_ready)
    else $error("no room after pop");
endmodule
bind bayer_adaptive_denoise_sharpen denoise_asserts #(.PIX_W(PIX_W)) i_denoise_asserts (
  .clk(clk), .reset(reset), .in_valid(in_valid), .in_ready(in_ready),
  .nb_centre(nb_centre), .nb_top(nb_top), .nb_bottom(nb_bottom), .nb_left(nb_left),
  .nb_right(nb_right), .in_eol(in_eol), .in_eof(in_eof), .filter_mode(filter_mode),
  .out_valid(out_valid), .out_ready(out_ready), .out_pixel(out_pixel),
  .out_eol(out_eol), .out_eof(out_eof), .out_class_dbg(out_class_dbg));

/* verif/pixel_sink.sv */
// downstream demosaic stand-in collecting filtered words
// assumes outputs sampled at posedge; ready moves just after it
`timescale 1ns/100ps
module pixel_sink #(
  parameter int PIX_W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hold,
  input wire logic slow,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [PIX_W-1:0] out_pixel,
  input wire logic out_eol,
  input wire logic out_eof
);
  logic [PIX_W+1:0] got_q[$];
  logic tick_q;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_q <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      tick_q <= ~tick_q;
      // slow mode takes every other cycle
      out_ready <= !hold && !(slow && tick_q);
    end
  end
  always @(posedge clk) begin
    if (!reset && out_valid && out_ready) begin
      got_q.push_back({out_eol, out_eof, out_pixel});
    end
  end
endmodule

/* verif/test_bayer_adaptive_denoise_sharpen.sv */
// self-checking bench for the bayer texture filter
// assumes the sink model and the bound checker are compiled with it
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0d got %0d", n, e, g); end end
module test_bayer_adaptive_denoise_sharpen;
  import denoise_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic in_valid = 0;
  logic sharpen_en = 0;
  logic hold = 0;
  logic slow = 0;
  logic in_ready, out_valid, out_ready, out_eol, out_eof;
  logic [11:0] nb_c = 0, nb_t = 0, nb_b = 0, nb_l = 0, nb_r = 0;
  logic [11:0] out_pixel;
  logic [5:0] flags = 0;
  logic [4:0] w2 = 5'h08, wd = 5'h0c, k = 5'h08;
  logic [12:0] tf = 13'h0014, te = 13'h001e, td = 13'h0190;
  filter_mode_e mode = MODE_ADAPTIVE;
  texture_e cls_dbg;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  bayer_adaptive_denoise_sharpen i_bayer_adaptive_denoise_sharpen (
    .clk(clk), .reset(reset), .in_valid(in_valid), .in_ready(in_ready),
    .nb_centre(nb_c), .nb_top(nb_t), .nb_bottom(nb_b), .nb_left(nb_l), .nb_right(nb_r),
    .at_top(flags[5]), .at_bottom(flags[4]), .at_left(flags[3]), .at_right(flags[2]),
    .in_eol(flags[1]), .in_eof(flags[0]), .filter_mode(mode), .sharpen_en(sharpen_en),
    .blur_wgt_2d(w2), .blur_wgt_dir(wd), .sharp_gain(k), .thr_flat(tf), .thr_edge(te),
    .thr_detail(td), .out_valid(out_valid), .out_ready(out_ready), .out_pixel(out_pixel),
    .out_eol(out_eol), .out_eof(out_eof), .out_class_dbg(cls_dbg));
  pixel_sink i_pixel_sink (.clk(clk), .reset(reset), .hold(hold), .slow(slow),
    .out_valid(out_valid), .out_ready(out_ready), .out_pixel(out_pixel),
    .out_eol(out_eol), .out_eof(out_eof));
  function automatic int ab(int x);
    return x < 0 ? -x : x;
  endfunction
  function automatic int mn(int x);
    return x > 16 ? 16 : x;
  endfunction
  function automatic int fref(int c, int t, int b, int l, int r, output int cls);
    int gh, gv, mx, a, lp, w, g, y, ad;
    gh = (ab(l - c) + ab(r - c)) >> 1;
    gv = (ab(t - c) + ab(b - c)) >> 1;
    mx = gh > gv ? gh : gv;
    cls = mx <= tf ? 0 : mx >= td ? 3 : ab(gh - gv) >= te ? (gv > gh ? 1 : 2) : 0;
    ad = mode == MODE_ADAPTIVE;
    a = c;
    lp = 0;
    w = 0;
    g = 0;
    if (mode == MODE_FIXED_BLUR || ad && cls == 0) begin
      a = (t + b + l + r + 4 * c) >> 3;
      w = w2;
    end else if (mode == MODE_FIXED_SHARP || ad && cls == 3 && sharpen_en) begin
      lp = 4 * c - t - b - l - r;
      g = k;
    end else if (ad && cls != 3) begin
      a = cls == 1 ? (l + r + 2 * c) >> 2 : (t + b + 2 * c) >> 2;
      lp = cls == 1 ? 2 * c - t - b : 2 * c - l - r;
      w = wd;
      g = sharpen_en ? k : 0;
    end
    y = c + (((a - c) * mn(w)) >>> 4) + ((lp * mn(g)) >>> 4);
    return y < 0 ? 0 : y > 4095 ? 4095 : y;
  endfunction
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic send(int c, int t, int b, int l, int r, logic [5:0] f);
    @(negedge clk);
    in_valid = 1;
    nb_c = 12'(c);
    nb_t = 12'(t);
    nb_b = 12'(b);
    nb_l = 12'(l);
    nb_r = 12'(r);
    flags = f;
    while (!in_ready) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic drop();
    @(negedge clk);
    in_valid = 0;
  endtask
  task automatic px(int c, int t, int b, int l, int r, logic [5:0] f);
    int n, cls, e;
    n = i_pixel_sink.got_q.size();
    send(c, t, b, l, r, f);
    drop();
    repeat (20) if (i_pixel_sink.got_q.size() == n) @(negedge clk);
    // missing neighbour mirrors the opposite one, centre if both gone
    e = fref(c, f[5] ? (f[4] ? c : b) : t, f[4] ? (f[5] ? c : t) : b,
      f[3] ? (f[2] ? c : r) : l, f[2] ? (f[3] ? c : l) : r, cls);
    `CHK("pixel", 12'(e), i_pixel_sink.got_q[n][11:0])
    `CHK("class", texture_e'(cls), cls_dbg)
    `CHK("marks", f[1:0], i_pixel_sink.got_q[n][13:12])
  endtask
  task automatic t_modes();
    sharpen_en = 1;
    for (int m = 0; m < 4; m++) begin
      mode = filter_mode_e'(m);
      px(1000, 1200, 1200, 1000, 1000, 6'h00);
    end
  endtask
  task automatic t_adapt();
    mode = MODE_ADAPTIVE;
    for (int p = 0; p < 2; p++) begin
      sharpen_en = p[0];
      w2 = p ? 5'h10 : 5'h08;
      wd = p ? 5'h04 : 5'h0c;
      k = p ? 5'h14 : 5'h08;
      td = p ? 13'h0258 : 13'h0190;
      px(1000, 1010, 1010, 1010, 1010, 6'h00);
      px(1000, 1200, 1200, 1000, 1000, 6'h00);
      px(1000, 1000, 1000, 1200, 1200, 6'h00);
      px(1000, 1500, 1500, 1450, 1450, 6'h00);
      // dense detail at both thresholds: pass-through, then 2d sharpen
      px(1000, 1700, 300, 1650, 450, 6'h00);
    end
  endtask
  task automatic t_border();
    px(1000, 0, 4000, 4095, 1200, 6'h38);
    // uniform patch, all borders and both markers: centre must come back
    px(2000, 2000, 2000, 2000, 2000, 6'h3f);
    px(1000, 0, 1200, 900, 4095, 6'h14);
  endtask
  task automatic t_fill();
    int n;
    n = i_pixel_sink.got_q.size();
    mode = MODE_BYPASS;
    hold = 1;
    for (int i = 0; i < 9; i++) send(100 + i, 0, 0, 0, 0, {4'h0, i[0], i == 8});
    drop();
    repeat (3) @(negedge clk);
    `CHK("in_ready", 1'b0, in_ready)
    hold = 0;
    slow = 1;
    repeat (60) if (i_pixel_sink.got_q.size() < n + 9) @(negedge clk);
    for (int i = 0; i < 9; i++) begin
      `CHK("word", {i[0], i == 8, 12'(100 + i)}, i_pixel_sink.got_q[n + i])
    end
    slow = 0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 0;
    t_modes();
    t_adapt();
    t_border();
    t_fill();
    results();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
endmodule

/* verilog/bayer_adaptive_denoise_sharpen.sv */
// texture-steered blur/sharpen stage for raw bayer pixels
// assumes the demosaic line buffer presents, per pixel, the same-colour
// cross neighbourhood (two rows/columns apart) with border flags, and a
// downstream demosaic stage that may stall through the output fifo
// Overview of operation
// - classify neighbourhood: flat, edge direction, dense detail
// - texture class steers the adaptive filter choice
// - flat or near-noise detail gets 2D blur
// - moderate detail blurs only along the edge
// - sharpen perpendicular to the blur direction
// - highest detail: bypass or 2D sharpen
// - fixed blur or fixed sharpen selectable
// - sharpening fixed kernel or edge-directed
// - weights and thresholds set filter strength
// - averaging kernels blur, laplacian kernels sharpen
// - window taken from the shared demosaic line buffer
`timescale 1ns/100ps

module bayer_adaptive_denoise_sharpen
  import denoise_pkg::*;
#(
  parameter int PIX_W = denoise_pkg::PIX_W_DEF,
  parameter int FIFO_DEPTH = denoise_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [PIX_W-1:0] nb_centre,
  input wire logic [PIX_W-1:0] nb_top,
  input wire logic [PIX_W-1:0] nb_bottom,
  input wire logic [PIX_W-1:0] nb_left,
  input wire logic [PIX_W-1:0] nb_right,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic at_left,
  input wire logic at_right,
  input wire logic in_eol,
  input wire logic in_eof,
  input wire denoise_pkg::filter_mode_e filter_mode,
  input wire logic sharpen_en,
  input wire logic [WGT_W-1:0] blur_wgt_2d,
  input wire logic [WGT_W-1:0] blur_wgt_dir,
  input wire logic [WGT_W-1:0] sharp_gain,
  input wire logic [PIX_W:0] thr_flat,
  input wire logic [PIX_W:0] thr_edge,
  input wire logic [PIX_W:0] thr_detail,
  output logic out_valid,
  input wire logic out_ready,
  output logic [PIX_W-1:0] out_pixel,
  output logic out_eol,
  output logic out_eof,
  output denoise_pkg::texture_e out_class_dbg
);

  import denoise_pkg::*;

  localparam int SW = PIX_W + 4;
  localparam int MW = SW + WGT_W + 2;
  localparam int FW = PIX_W + MARK_W;

  generate
    if (PIX_W < 8 || PIX_W > 16) begin : g_bad_width
      $error("bayer filter: pixel width must be 8 to 16");
    end
  endgenerate

  function automatic logic [PIX_W:0] abs_diff(input logic [PIX_W-1:0] a,
                                              input logic [PIX_W-1:0] b);
    abs_diff = (a > b) ? (PIX_W+1)'(a - b) : (PIX_W+1)'(b - a);
  endfunction

  // one combined kernel: c + w*(avg-c)/16 + k*lap/16, clamped to range
  function automatic logic [PIX_W-1:0] filt(input logic [PIX_W-1:0] c,
                                            input logic signed [SW-1:0] avg,
                                            input logic signed [SW-1:0] lap,
                                            input logic [WGT_W-1:0] w,
                                            input logic [WGT_W-1:0] k);
    logic signed [MW-1:0] cs;
    logic signed [MW-1:0] as;
    logic signed [MW-1:0] ls;
    logic signed [MW-1:0] ws;
    logic signed [MW-1:0] ks;
    logic signed [MW-1:0] sum;
    logic signed [MW-1:0] top;
    cs = MW'({1'h0, c});
    as = MW'(avg);
    ls = MW'(lap);
    ws = MW'({1'h0, ((w > WGT_W'(WGT_MAX)) ? WGT_W'(WGT_MAX) : w)});
    ks = MW'({1'h0, ((k > WGT_W'(WGT_MAX)) ? WGT_W'(WGT_MAX) : k)});
    top = MW'({1'h0, {PIX_W{1'h1}}});
    sum = cs + (((as - cs) * ws) >>> WGT_SHIFT) + ((ls * ks) >>> WGT_SHIFT);
    if (sum < 0) begin
      filt = '0;
    end else if (sum > top) begin
      filt = {PIX_W{1'h1}};
    end else begin
      filt = sum[PIX_W-1:0];
    end
  endfunction

  // stage 1: border fill and texture class
  logic [PIX_W-1:0] fill_t;
  logic [PIX_W-1:0] fill_b;
  logic [PIX_W-1:0] fill_l;
  logic [PIX_W-1:0] fill_r;
  logic [PIX_W:0] grad_h;
  logic [PIX_W:0] grad_v;
  logic [PIX_W:0] grad_max;
  logic [PIX_W:0] grad_skew;
  texture_e tex_d;

  always_comb begin
    // mirror across the centre, then fall back to the centre itself
    fill_t = at_top ? (at_bottom ? nb_centre : nb_bottom) : nb_top;
    fill_b = at_bottom ? (at_top ? nb_centre : nb_top) : nb_bottom;
    fill_l = at_left ? (at_right ? nb_centre : nb_right) : nb_left;
    fill_r = at_right ? (at_left ? nb_centre : nb_left) : nb_right;
  end

  always_comb begin
    grad_h = (PIX_W+1)'((abs_diff(fill_l, nb_centre) + abs_diff(fill_r, nb_centre)) >> 1);
    grad_v = (PIX_W+1)'((abs_diff(fill_t, nb_centre) + abs_diff(fill_b, nb_centre)) >> 1);
    grad_max = (grad_h > grad_v) ? grad_h : grad_v;
    grad_skew = abs_diff(grad_h[PIX_W-1:0], grad_v[PIX_W-1:0]);
    if (grad_max <= thr_flat) begin
      tex_d = TEX_FLAT;
    end else if (grad_max >= thr_detail) begin
      tex_d = TEX_DETAIL;
    end else if (grad_skew >= thr_edge) begin
      // strong vertical change means the edge itself runs horizontally
      tex_d = (grad_v > grad_h) ? TEX_EDGE_H : TEX_EDGE_V;
    end else begin
      tex_d = TEX_FLAT;
    end
  end

  logic s1_valid_q;
  logic [PIX_W-1:0] c_q;
  logic [PIX_W-1:0] t_q;
  logic [PIX_W-1:0] b_q;
  logic [PIX_W-1:0] l_q;
  logic [PIX_W-1:0] r_q;
  logic eol_q;
  logic eof_q;
  texture_e tex_q;
  logic fifo_wr_ready;
  logic s1_advance;

  assign s1_advance = !s1_valid_q || fifo_wr_ready;
  assign in_ready = s1_advance;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_valid_q <= 1'h0;
    end else if (s1_advance) begin
      s1_valid_q <= in_valid;
    end
  end

  // border-filled window registered, only the centre straight off the shared line buffer tap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c_q <= '0;
      t_q <= '0;
      b_q <= '0;
      l_q <= '0;
      r_q <= '0;
      eol_q <= 1'h0;
      eof_q <= 1'h0;
      tex_q <= TEX_FLAT;
    end else if (in_valid && s1_advance) begin
      c_q <= nb_centre;
      t_q <= fill_t;
      b_q <= fill_b;
      l_q <= fill_l;
      r_q <= fill_r;
      eol_q <= in_eol;
      eof_q <= in_eof;
      tex_q <= tex_d;
    end
  end

  // stage 2: kernels and selection, result goes straight into the fifo
  logic signed [SW-1:0] cc;
  logic signed [SW-1:0] avg_2d;
  logic signed [SW-1:0] avg_h;
  logic signed [SW-1:0] avg_v;
  logic signed [SW-1:0] lap_2d;
  logic signed [SW-1:0] lap_h;
  logic signed [SW-1:0] lap_v;
  logic [WGT_W-1:0] k_dir;
  logic [PIX_W-1:0] pix_d;

  always_comb begin
    cc = SW'({1'h0, c_q});
    avg_2d = (SW'({1'h0, t_q}) + SW'({1'h0, b_q}) + SW'({1'h0, l_q}) + SW'({1'h0, r_q})
              + (cc <<< CTR2D_SHIFT)) >>> AVG2D_SHIFT;
    avg_h = (SW'({1'h0, l_q}) + SW'({1'h0, r_q}) + (cc <<< CTR1D_SHIFT)) >>> AVG1D_SHIFT;
    avg_v = (SW'({1'h0, t_q}) + SW'({1'h0, b_q}) + (cc <<< CTR1D_SHIFT)) >>> AVG1D_SHIFT;
    lap_2d = (cc <<< CTR2D_SHIFT) - SW'({1'h0, t_q}) - SW'({1'h0, b_q})
             - SW'({1'h0, l_q}) - SW'({1'h0, r_q});
    lap_h = (cc <<< CTR1D_SHIFT) - SW'({1'h0, l_q}) - SW'({1'h0, r_q});
    lap_v = (cc <<< CTR1D_SHIFT) - SW'({1'h0, t_q}) - SW'({1'h0, b_q});
    k_dir = sharpen_en ? sharp_gain : '0;
    case (filter_mode)
      MODE_BYPASS: begin
        pix_d = c_q;
      end
      MODE_FIXED_BLUR: begin
        pix_d = filt(c_q, avg_2d, lap_2d, blur_wgt_2d, '0);
      end
      MODE_FIXED_SHARP: begin
        pix_d = filt(c_q, cc, lap_2d, '0, sharp_gain);
      end
      MODE_ADAPTIVE: begin
        case (tex_q)
          TEX_FLAT: begin
            pix_d = filt(c_q, avg_2d, lap_2d, blur_wgt_2d, '0);
          end
          TEX_EDGE_H: begin
            // blur along the row, sharpen across it
            pix_d = filt(c_q, avg_h, lap_v, blur_wgt_dir, k_dir);
          end
          TEX_EDGE_V: begin
            pix_d = filt(c_q, avg_v, lap_h, blur_wgt_dir, k_dir);
          end
          TEX_DETAIL: begin
            pix_d = sharpen_en ? filt(c_q, cc, lap_2d, '0, sharp_gain) : c_q;
          end
          default: begin
            pix_d = c_q;
          end
        endcase
      end
      default: begin
        pix_d = c_q;
      end
    endcase
  end

  logic [FW-1:0] fifo_rd_data;

  pixel_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .clk(clk),
    .reset(reset),
    .wr_valid(s1_valid_q),
    .wr_ready(fifo_wr_ready),
    .wr_data({eof_q, eol_q, pix_d}),
    .rd_valid(out_valid),
    .rd_ready(out_ready),
    .rd_data(fifo_rd_data)
  );

  assign out_pixel = fifo_rd_data[PIX_W-1:0];
  assign out_eol = fifo_rd_data[PIX_W];
  assign out_eof = fifo_rd_data[PIX_W+1];

  // last class taken, for tuning thresholds in the lab
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_class_dbg <= TEX_FLAT;
    end else if (s1_valid_q && fifo_wr_ready) begin
      out_class_dbg <= tex_q;
    end
  end

endmodule

/* verilog/denoise_pkg.sv */
// constants and types shared by the bayer texture filter, its checker and its bench
// assumes 12-bit raw samples and a single pipeline clock
package denoise_pkg;

  localparam int PIX_W_DEF = 12;
  localparam int FIFO_DEPTH_DEF = 8;
  // weights and gains are in sixteenths, 0 to 16
  localparam int WGT_W = 5;
  localparam int WGT_SHIFT = 4;
  localparam int WGT_MAX = 16;
  localparam int AVG2D_SHIFT = 3;
  localparam int AVG1D_SHIFT = 2;
  localparam int CTR2D_SHIFT = 2;
  localparam int CTR1D_SHIFT = 1;
  localparam int MARK_W = 2;

  typedef enum logic [1:0] {
    MODE_ADAPTIVE,
    MODE_FIXED_BLUR,
    MODE_FIXED_SHARP,
    MODE_BYPASS
  } filter_mode_e;

  typedef enum logic [1:0] {
    TEX_FLAT,
    TEX_EDGE_H,
    TEX_EDGE_V,
    TEX_DETAIL
  } texture_e;

endpackage

/* verilog/pixel_fifo.sv */
// small synchronous fifo for filtered pixels and their markers
// assumes both sides on clk; head word is read straight from storage flops
`timescale 1ns/100ps

module pixel_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("pixel_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign wr_ready = (count_q != (AW+1)'(DEPTH));
  assign rd_valid = (count_q != '0);
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem_q[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'h1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'h1;
      end
    end
  end

endmodule
